// [pkg/ppc_cfg.svh]
// register offsets, field positions and reset values of the pad-control bank
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ****************************************************************
// layout
// ****************************************************************
`define PPC_PIN_COUNT 7
`define PPC_FIELD_MSB 6
`define PPC_FIELD_LSB 0
`define PPC_ADR_WIDTH 8

// ****************************************************************
// byte offsets on the register bus
// ****************************************************************
`define PPC_OFS_PULLUP 8'h00
`define PPC_OFS_SLEW 8'h04
`define PPC_OFS_DRIVE 8'h08

// ****************************************************************
// reset values
// ****************************************************************
`define PPC_REG_RST 7'h00
`define PPC_OUT_EN_N_RST 7'h7F
`define PPC_RDATA_RST 32'h0000_0000

`endif

// [pkg/ppc_pkg.sv]
// types shared by the pad-control bank
`default_nettype none
`include "ppc_cfg.svh"

package ppc_pkg;

	// one bit per port pin
	typedef logic [`PPC_FIELD_MSB:`PPC_FIELD_LSB] ppc_pins_t;

	// register selected by a bus address
	typedef enum logic [1:0] {
		PPC_SEL_PULLUP = 2'h0,
		PPC_SEL_SLEW = 2'h1,
		PPC_SEL_DRIVE = 2'h2,
		PPC_SEL_NONE = 2'h3
	} ppc_sel_t;

endpackage
`default_nettype wire

// [hw/ppc_pad_gate.sv]
// per-pin qualification of pad controls by the pin direction
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"

module ppc_pad_gate (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// settings and direction
	input wire ppc_pkg::ppc_pins_t pullup_enable_bits,
	input wire ppc_pkg::ppc_pins_t slew_enable_bits,
	input wire ppc_pkg::ppc_pins_t drive_strength_bits,
	input wire ppc_pkg::ppc_pins_t pin_direction_bits,
	// pad controls
	output ppc_pkg::ppc_pins_t pad_pullup,
	output ppc_pkg::ppc_pins_t pad_slew_limit,
	output ppc_pkg::ppc_pins_t pad_high_drive,
	output ppc_pkg::ppc_pins_t pad_out_en_n
);

	ppc_pkg::ppc_pins_t next_pad_pullup;
	ppc_pkg::ppc_pins_t next_pad_slew_limit;
	ppc_pkg::ppc_pins_t next_pad_high_drive;
	ppc_pkg::ppc_pins_t next_pad_out_en_n;

	// ****************************************************************
	// per-pin gating
	// ****************************************************************
	// output pins never keep a pullup; input pins ignore slew and drive
	genvar gi;
	generate
		for (gi = 0; gi < `PPC_PIN_COUNT; gi++) begin : g_pin
			assign next_pad_pullup[gi] = pullup_enable_bits[gi] & ~pin_direction_bits[gi];
			assign next_pad_slew_limit[gi] = slew_enable_bits[gi] & pin_direction_bits[gi];
			assign next_pad_high_drive[gi] = drive_strength_bits[gi] & pin_direction_bits[gi];
			assign next_pad_out_en_n[gi] = ~pin_direction_bits[gi];
		end
	endgenerate

	// registered so the pads see glitch-free levels; reset leaves pins floating inputs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pad_pullup <= `PPC_REG_RST;
			pad_slew_limit <= `PPC_REG_RST;
			pad_high_drive <= `PPC_REG_RST;
			pad_out_en_n <= `PPC_OUT_EN_N_RST;
		end else begin
			pad_pullup <= next_pad_pullup;
			pad_slew_limit <= next_pad_slew_limit;
			pad_high_drive <= next_pad_high_drive;
			pad_out_en_n <= next_pad_out_en_n;
		end
	end

endmodule // ppc_pad_gate
`default_nettype wire

// [hw/ppc_top.sv]
// pad-control register bank for a seven-pin port, wishbone slave
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"

module ppc_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PPC_ADR_WIDTH-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// direction from the port data/direction logic, same clock
	input wire ppc_pkg::ppc_pins_t pin_direction_bits,
	// pad controls
	output ppc_pkg::ppc_pins_t pad_pullup,
	output ppc_pkg::ppc_pins_t pad_slew_limit,
	output ppc_pkg::ppc_pins_t pad_high_drive,
	output ppc_pkg::ppc_pins_t pad_out_en_n
);

	// ****************************************************************
	// address decode
	// ****************************************************************
	// shared by the write path and the read path
	function automatic ppc_pkg::ppc_sel_t ppc_decode(input logic [`PPC_ADR_WIDTH-1:0] adr);
		unique case (adr)
			`PPC_OFS_PULLUP: ppc_decode = ppc_pkg::PPC_SEL_PULLUP;
			`PPC_OFS_SLEW: ppc_decode = ppc_pkg::PPC_SEL_SLEW;
			`PPC_OFS_DRIVE: ppc_decode = ppc_pkg::PPC_SEL_DRIVE;
			default: ppc_decode = ppc_pkg::PPC_SEL_NONE;
		endcase
	endfunction

	// ****************************************************************
	// bus handshake and storage
	// ****************************************************************
	ppc_pkg::ppc_pins_t regs [3];
	ppc_pkg::ppc_pins_t next_regs [3];
	logic [31:0] next_wb_dat_o;
	logic next_wb_ack_o;
	logic req;
	logic wr_fire;
	ppc_pkg::ppc_sel_t sel;

	assign req = wb_cyc_i & wb_stb_i;
	// write lands on the edge where the master samples ack
	assign wr_fire = req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign sel = ppc_decode(wb_adr_i);

	// next state: ack one cycle after request, dropped the cycle after
	always_comb begin
		next_wb_ack_o = req & ~wb_ack_o;
		next_wb_dat_o = wb_dat_o;
		for (int i = 0; i < 3; i++) begin
			next_regs[i] = regs[i];
		end
		if (wr_fire && sel != ppc_pkg::PPC_SEL_NONE) begin
			// bit 7 and above are dropped: field is only 6:0
			next_regs[sel] = wb_dat_i[`PPC_FIELD_MSB:`PPC_FIELD_LSB];
		end
		if (req && !wb_ack_o) begin
			// unmapped addresses answer with zero rather than stall the bus
			if (sel == ppc_pkg::PPC_SEL_NONE) begin
				next_wb_dat_o = `PPC_RDATA_RST;
			end else begin
				next_wb_dat_o = {25'h000_0000, regs[sel]};
			end
		end
	end

	// registers only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `PPC_RDATA_RST;
			for (int i = 0; i < 3; i++) begin
				regs[i] <= `PPC_REG_RST;
			end
		end else begin
			wb_ack_o <= next_wb_ack_o;
			wb_dat_o <= next_wb_dat_o;
			for (int i = 0; i < 3; i++) begin
				regs[i] <= next_regs[i];
			end
		end
	end

	// ****************************************************************
	// pad qualification
	// ****************************************************************
	ppc_pad_gate u_gate (
		.mclk(mclk),
		.rst(rst),
		.pullup_enable_bits(regs[ppc_pkg::PPC_SEL_PULLUP]),
		.slew_enable_bits(regs[ppc_pkg::PPC_SEL_SLEW]),
		.drive_strength_bits(regs[ppc_pkg::PPC_SEL_DRIVE]),
		.pin_direction_bits(pin_direction_bits),
		.pad_pullup(pad_pullup),
		.pad_slew_limit(pad_slew_limit),
		.pad_high_drive(pad_high_drive),
		.pad_out_en_n(pad_out_en_n)
	);

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_wr(logic [`PPC_ADR_WIDTH-1:0] ofs);
		req && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == ofs;
	endsequence

	// write to pullup register, then the register holds the written field on the next cycle
	AST_PULLUP_WRITE: assert property (
		s_wr(`PPC_OFS_PULLUP) |=> regs[ppc_pkg::PPC_SEL_PULLUP] == $past(wb_dat_i[6:0]))
		else $error("pullup register did not take written value");

	AST_PULLUP_OFF_OUT: assert property (
		!$past(rst) |-> (pad_pullup & $past(pin_direction_bits)) == 7'h00)
		else $error("pullup active on an output pin");

	AST_PULLUP_ON_IN: assert property (
		!$past(rst) |-> pad_pullup == ($past(regs[0]) & ~$past(pin_direction_bits)))
		else $error("pullup pad does not follow enable on input pin");

	AST_SLEW_WRITE: assert property (
		s_wr(`PPC_OFS_SLEW) |=> ##1 pad_slew_limit == ($past(wb_dat_i[6:0], 2)
			& $past(pin_direction_bits)))
		else $error("slew write did not reach output pins");

	AST_SLEW_INPUT_QUIET: assert property (
		!$past(rst) |-> (pad_slew_limit & ~$past(pin_direction_bits)) == 7'h00)
		else $error("slew control active on an input pin");

	AST_DRIVE_WRITE: assert property (
		s_wr(`PPC_OFS_DRIVE) |=> ##1 pad_high_drive == ($past(wb_dat_i[6:0], 2)
			& $past(pin_direction_bits)))
		else $error("drive strength did not follow write");

	AST_DRIVER_EN: assert property (
		!$past(rst) |-> pad_out_en_n == ~$past(pin_direction_bits))
		else $error("output driver enable does not match direction");

	AST_RESET_PADS: assert property (
		$past(rst) |-> pad_out_en_n == 7'h7F && pad_pullup == 7'h00)
		else $error("pins not floating inputs after reset");

	AST_BIT7_ZERO: assert property (
		wb_ack_o |-> wb_dat_o[31:7] == 25'h000_0000)
		else $error("bits above field read nonzero");

	AST_ACK_PULSE: assert property (
		req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single-cycle answer");

	COV_PULLUP_WRITE: cover property (s_wr(`PPC_OFS_PULLUP));
	COV_SLEW_READ: cover property (req && !wb_we_i && wb_ack_o && wb_adr_i == `PPC_OFS_SLEW);
	COV_PULLUP_ACTIVE: cover property (pad_pullup != 7'h00);
	COV_HIGH_DRIVE: cover property (pad_high_drive != 7'h00);

endmodule // ppc_top
`default_nettype wire

// [tb/ppc_pad_model.sv]
// behavioural model of the seven port pad cells
`timescale 1ns/100ps
`default_nettype none

module ppc_pad_model (
	// pad controls
	input wire ppc_pkg::ppc_pins_t pad_pullup,
	input wire ppc_pkg::ppc_pins_t pad_out_en_n,
	// pin state seen by the bench
	output ppc_pkg::ppc_pins_t pin_floating
);
	// neither driver nor pullup: the pin floats
	assign pin_floating = pad_out_en_n & ~pad_pullup;
endmodule // ppc_pad_model
`default_nettype wire

// [tb/port_pin_pad_control_tb.sv]
// self-checking bench for the pad-control register bank
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"

module port_pin_pad_control_tb;
	logic mclk, rst, cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, dat_o, lfsr;
	ppc_pkg::ppc_pins_t dir, pu, sl, hd, oen, flt;
	ppc_pkg::ppc_pins_t exp_r [3];
	ppc_pkg::ppc_pins_t got [5];
	logic [7:0] ofs [3];
	int err_count, checked, cycles;

	ppc_top dut_u (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.pin_direction_bits(dir), .pad_pullup(pu), .pad_slew_limit(sl),
		.pad_high_drive(hd), .pad_out_en_n(oen));
	ppc_pad_model pad_u (.pad_pullup(pu), .pad_out_en_n(oen), .pin_floating(flt));

	// gather pad outputs so one loop checks them all
	always_comb got = '{pu, sl, hd, oen, flt};

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// expected pad output k from register images and direction
	function automatic ppc_pkg::ppc_pins_t pad_exp(input int k);
		case (k)
			0: return exp_r[0] & ~dir;
			1: return exp_r[1] & dir;
			2: return exp_r[2] & dir;
			3: return ~dir;
			default: return ~dir & ~exp_r[0];
		endcase
	endfunction

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask

	// classic single wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		// no cycle count assumed: only the bench timeout ends a wait
		do begin
			@(posedge mclk);
		end while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic check_pads();
		repeat (2) @(posedge mclk);
		for (int k = 0; k < 5; k++) begin
			chk($sformatf("pad%0d", k), 32'(pad_exp(k)), 32'(got[k]));
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************************************
	// clock, timeout and sequence
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			report_and_stop();
		end
	end

	initial begin
		// cycles belongs to the timeout process alone; an int starts at zero
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		dir = 7'h00;
		lfsr = 32'h2BFF;
		err_count = 0;
		checked = 0;
		ofs = '{`PPC_OFS_PULLUP, `PPC_OFS_SLEW, `PPC_OFS_DRIVE};
		exp_r = '{7'h00, 7'h00, 7'h00};
		repeat (5) @(posedge mclk);
		chk("oen in reset", 32'h7F, 32'(oen));
		chk("float in reset", 32'h7F, 32'(flt));
		rst <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			wb(1'b0, ofs[k], 4'hF, 32'h0);
			chk("reg after reset", 32'h0, rdat);
		end
		$display("test reset done");
		// first writes all-ones with dir 0/7F, then random traffic
		for (int i = 0; i < 40; i++) begin
			int k;
			lfsr = nxt(lfsr);
			k = int'(lfsr[25:24]) % 3;
			dir <= (i < 6) ? (i[0] ? 7'h7F : 7'h00) : lfsr[22:16];
			wb(1'b1, ofs[k], (i < 6) ? 4'hF : lfsr[11:8], (i < 6) ? 32'hFFFF_FFFF : lfsr);
			if (i < 6 || lfsr[8])
				exp_r[k] = (i < 6) ? 7'h7F : lfsr[6:0];
			wb(1'b0, ofs[k], 4'hF, 32'h0);
			chk("reg read", {25'h0, exp_r[k]}, rdat);
			wb(1'b1, 8'h0C, 4'hF, lfsr);
			wb(1'b0, 8'h0C, 4'hF, 32'h0);
			chk("unmapped read", 32'h0, rdat);
			check_pads();
		end
		$display("test random traffic done");
		// direction logic shares the system reset, so pins fall back to inputs
		rst <= 1'b1;
		dir <= 7'h00;
		@(posedge mclk);
		chk("oen in second reset", 32'h7F, 32'(oen));
		chk("float in second reset", 32'h7F, 32'(flt));
		rst <= 1'b0;
		exp_r = '{7'h00, 7'h00, 7'h00};
		for (int k = 0; k < 3; k++) begin
			wb(1'b0, ofs[k], 4'hF, 32'h0);
			chk("reg after second reset", 32'h0, rdat);
		end
		check_pads();
		$display("test second reset done");
		report_and_stop();
	end
endmodule // port_pin_pad_control_tb
`default_nettype wire
